// ### design/flash_device.sv
// Device end: reset, sleep, wake, identification and parameter read-out
// What this block does
// - reset runs only if execute directly follows arm
// - any other command cancels the armed reset
// - mode-bit clear leaves continuous read mode
// - host sends eight ones on lowest line only
// - host clears mode bits before resets
// - sleep command needs select high after bit eight
// - sleep entered within sleep-entry time after select
// - asleep, only wake command recognised
// - hardware reset always returns normal operation
// - wake time passes before commands are accepted
// - identification after three dummy bytes, msb first
// - beyond id zeros driven; select high ends it
// - identification ignored while busy
// - quad mode uses all four lines, except mode-bit clear on lowest line
// - parameter read uses separate address space
// - header at zero, table at 0300h
// - parameter space is read-only
// - reset at select rise, recovery time, reload
// - arm is 66h, execute is 99h
// - soft reset keeps protect and lock bits
`timescale 1ns/100ps
`include "flash_cfg.svh"
module flash_device
	import flash_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h3C // Arbitrary value
)(
	input  wire logic         mclk,
	input  wire logic         nrst,
	flash_link_if.dev         link,
	input  wire logic         quad_mode,
	input  wire logic         busy,
	input  wire logic         cont_read_enter,
	input  wire logic         cfg_wr,
	input  wire logic [9:0]   cfg_wr_data,
	output logic              ready_q,
	output logic              sleeping_q,
	output logic              cont_read_q,
	output logic              soft_reset_q,
	output logic [7:0]        vol_cfg_q,
	output logic [1:0]        prot_q
);
	localparam logic [15:0] SLEEP_CYC = 16'(`SLEEP_ENTRY_CYC);
	localparam logic [15:0] WAKE_CYC  = 16'(`WAKE_CYC);
	localparam logic [15:0] RESET_CYC = 16'(`RESET_REC_CYC);
	if (`SLEEP_ENTRY_CYC < 1 || `WAKE_CYC < 1 || `RESET_REC_CYC < 1)
	begin : g_bad_timing
		$error("timing counts must be at least one cycle");
	end

	function automatic logic [7:0] param_byte(input logic [23:0] a);
		logic [7:0] b;
		b = `PARAM_UNDEF;
		if ((a >> 3) == (`PARAM_HDR_BASE >> 3))
		begin
			unique case (a[2:0])
				3'd0: b = `PARAM_HDR0;
				3'd1: b = `PARAM_HDR1;
				3'd2: b = `PARAM_HDR2;
				3'd3: b = `PARAM_HDR3;
				3'd4: b = `PARAM_HDR4;
				3'd5: b = `PARAM_HDR5;
				3'd6: b = `PARAM_HDR6;
				3'd7: b = `PARAM_UNDEF;
			endcase
		end
		else if (a >= `PARAM_TBL_BASE &&
			a < `PARAM_TBL_BASE + `PARAM_TBL_LEN)
			b = `PARAM_TBL_FILL;
		return b;
	endfunction : param_byte

	// Link side, on the serial clock; select high clears the frame
	logic [2:0]  stat_q;
	logic [2:0]  stat_s1_q;
	logic [2:0]  stat_s2_q;
	logic [5:0]  edge_q;
	logic [7:0]  op_q;
	logic [7:0]  lane0_q;
	logic [23:0] addr_q;
	logic        quad_s;
	logic        blocked_s;
	logic        busy_s;
	logic [5:0]  instr_edges;
	assign quad_s      = stat_s2_q[2];
	assign blocked_s   = stat_s2_q[1];
	assign busy_s      = stat_s2_q[0];
	assign instr_edges = quad_s ? `INSTR_EDGES_4 : `INSTR_EDGES_1;

	always_ff @(posedge link.sck or negedge nrst)
	begin
		if (!nrst)
		begin
			stat_s1_q <= 3'b000;
			stat_s2_q <= 3'b000;
		end
		else
		begin
			stat_s1_q <= stat_q;
			stat_s2_q <= stat_s1_q;
		end
	end

	always_ff @(posedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			edge_q  <= 6'd0;
			op_q    <= 8'h00;
			lane0_q <= 8'h00;
			addr_q  <= 24'h0;
		end
		else
		begin
			if (edge_q != `EDGE_MAX)
				edge_q <= edge_q + 6'd1;
			if (edge_q < `INSTR_EDGES_1)
				lane0_q <= {lane0_q[6:0], link.io[0]};
			if (edge_q < instr_edges)
				op_q <= quad_s ? {op_q[3:0], link.io} :
					{op_q[6:0], link.io[0]};
			if (op_q == `OP_PARAM_READ && edge_q >= instr_edges &&
				edge_q < (quad_s ? `PARAM_ADDR_END_4 : `PARAM_ADDR_END_1))
				addr_q <= quad_s ? {addr_q[19:0], link.io} :
					{addr_q[22:0], link.io[0]};
		end
	end

	// Frame contents frozen at select rise for the clock-side decoder
	logic [5:0] len_cap_q;
	logic [7:0] op_cap_q;
	logic [7:0] lane0_cap_q;
	always_ff @(posedge link.cs_n or negedge nrst)
	begin
		if (!nrst)
		begin
			len_cap_q   <= 6'd0;
			op_cap_q    <= 8'h00;
			lane0_cap_q <= 8'h00;
		end
		else
		begin
			len_cap_q   <= edge_q;
			op_cap_q    <= op_q;
			lane0_cap_q <= lane0_q;
		end
	end

	// Read-out on falling edges
	logic        rd_id;
	logic        rd_param;
	logic        load;
	logic        wrap;
	logic [7:0]  cur;
	logic [7:0]  sh_q;
	logic [2:0]  unit_q;
	logic        active_q;
	logic [23:0] raddr_q;
	logic [3:0]  io_out_q;
	logic [3:0]  io_oe_q;
	assign rd_id    = (op_q == `OP_WAKE_ID) && !blocked_s && !busy_s;
	assign rd_param = (op_q == `OP_PARAM_READ) && !blocked_s;
	assign load = (rd_id && edge_q == (quad_s ? `ID_START_4 : `ID_START_1))
		|| (rd_param &&
		edge_q == (quad_s ? `PARAM_START_4 : `PARAM_START_1));
	assign wrap = active_q && unit_q == (quad_s ? 3'd1 : 3'd7);

	always_comb
	begin
		if (load)
			cur = rd_id ? DEVICE_ID : param_byte(addr_q);
		else if (wrap)
			cur = rd_id ? 8'h00 : param_byte(raddr_q);
		else
			cur = quad_s ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
	end

	always_ff @(negedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			sh_q     <= 8'h00;
			unit_q   <= 3'd0;
			active_q <= 1'b0;
			raddr_q  <= 24'h0;
			io_out_q <= 4'h0;
			io_oe_q  <= 4'h0;
		end
		else if (load || active_q)
		begin
			sh_q     <= cur;
			active_q <= 1'b1;
			unit_q   <= (load || wrap) ? 3'd0 : unit_q + 3'd1;
			if (load)
				raddr_q <= addr_q + 24'h1;
			else if (wrap)
				raddr_q <= raddr_q + 24'h1;
			io_out_q <= quad_s ? cur[7:4] : {2'b00, cur[7], 1'b0};
			io_oe_q  <= quad_s ? 4'hF : 4'h2;
		end
	end
	assign link.d_io_out = io_out_q;
	assign link.d_io_oe  = io_oe_q;

	// Clock side: select synchroniser and command decoder
	logic     cs_s1_q;
	logic     cs_s2_q;
	logic     cs_s3_q;
	logic     frame_end;
	logic     whole;
	logic [7:0] op;
	logic [5:0] need;
	logic     arm_q;
	logic [15:0] timer_q;
	mode_type mode_q;
	assign frame_end = cs_s2_q && !cs_s3_q;
	assign need  = (quad_mode && !cont_read_q) ? `INSTR_EDGES_4 :
		`INSTR_EDGES_1;
	assign whole = frame_end && len_cap_q >= need;
	// Continuous read treats the first byte as address: lowest line only
	assign op = cont_read_q ? lane0_cap_q : op_cap_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			stat_q  <= 3'b000;
		end
		else
		begin
			cs_s1_q <= link.cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			stat_q  <= {quad_mode, (mode_q != ST_NORMAL) || cont_read_q,
				busy};
		end
	end

	// Asynchronous reset lands in normal operation, also from sleep
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_q       <= ST_NORMAL;
			timer_q      <= 16'h0000;
			arm_q        <= 1'b0;
			soft_reset_q <= 1'b0;
		end
		else
		begin
			soft_reset_q <= 1'b0;
			if (timer_q != 16'h0000)
				timer_q <= timer_q - 16'h0001;
			unique case (mode_q)
				ST_NORMAL:
				begin
					if (whole && !cont_read_q)
					begin
						arm_q <= (op == `OP_RESET_ARM);
						if (op == `OP_RESET_EXEC && arm_q)
						begin
							mode_q  <= ST_RESETTING;
							timer_q <= RESET_CYC;
						end
						else if (op == `OP_DEEP_SLEEP && len_cap_q == need)
						begin
							mode_q  <= ST_ENTERING;
							timer_q <= SLEEP_CYC;
						end
					end
					else if (whole)
						arm_q <= 1'b0;
				end
				ST_ENTERING:
					if (timer_q == 16'h0001)
						mode_q <= ST_SLEEP;
				ST_SLEEP:
					if (whole && op == `OP_WAKE_ID)
					begin
						mode_q  <= ST_WAKING;
						timer_q <= WAKE_CYC;
					end
				ST_WAKING:
					if (timer_q == 16'h0001)
						mode_q <= ST_NORMAL;
				ST_RESETTING:
					if (timer_q == 16'h0001)
					begin
						mode_q       <= ST_NORMAL;
						arm_q        <= 1'b0;
						soft_reset_q <= 1'b1;
					end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cont_read_q <= 1'b0;
		else if (mode_q == ST_RESETTING && timer_q == 16'h0001)
			cont_read_q <= 1'b0;
		// Entry request wins over a clear in the same cycle
		else if (mode_q == ST_NORMAL && cont_read_enter)
			cont_read_q <= 1'b1;
		else if (mode_q == ST_NORMAL && whole && cont_read_q &&
			op == `OP_MODE_BIT_CLEAR)
			cont_read_q <= 1'b0;
	end

	// Soft reset reloads general bits only; protection survives
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			vol_cfg_q <= `VOL_CFG_DEFAULT;
			prot_q    <= 2'b00;
		end
		else if (mode_q == ST_RESETTING && timer_q == 16'h0001)
			vol_cfg_q <= `VOL_CFG_DEFAULT;
		else if (cfg_wr && mode_q == ST_NORMAL)
		begin
			vol_cfg_q <= cfg_wr_data[7:0];
			prot_q    <= cfg_wr_data[9:8];
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ready_q    <= 1'b1;
			sleeping_q <= 1'b0;
		end
		else
		begin
			ready_q    <= (mode_q == ST_NORMAL);
			sleeping_q <= (mode_q == ST_SLEEP);
		end
	end
	// The parameter space has no write path at all
endmodule : flash_device

// ### design/flash_cfg.svh
// Opcodes, parameter-space layout and timing figures for the flash link
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH
`define OP_RESET_ARM      8'h66
`define OP_RESET_EXEC     8'h99
`define OP_MODE_BIT_CLEAR 8'hFF
`define OP_DEEP_SLEEP     8'hB9
`define OP_WAKE_ID        8'hAB
`define OP_PARAM_READ     8'h5A
`define INSTR_EDGES_1     6'd8
`define INSTR_EDGES_4     6'd2
`define ID_START_1        6'd32
`define ID_START_4        6'd8
`define PARAM_ADDR_END_1  6'd32
`define PARAM_ADDR_END_4  6'd8
`define PARAM_START_1     6'd40
`define PARAM_START_4     6'd16
`define EDGE_MAX          6'h3F
`define PARAM_HDR_BASE    24'h000000
`define PARAM_TBL_BASE    24'h000300
`define PARAM_TBL_LEN     24'h000050
`define PARAM_TBL_FILL    8'hA5
`define PARAM_UNDEF       8'hFF
`define PARAM_HDR0        8'h53
`define PARAM_HDR1        8'h46
`define PARAM_HDR2        8'h44
`define PARAM_HDR3        8'h50
`define PARAM_HDR4        8'h06
`define PARAM_HDR5        8'h01
`define PARAM_HDR6        8'h01
`define MCLK_NS           50
`define SLEEP_ENTRY_NS    3000
`define WAKE_NS           3000
`define RESET_REC_NS      10000
`define SLEEP_ENTRY_CYC   (`SLEEP_ENTRY_NS / `MCLK_NS)
`define WAKE_CYC          ((`WAKE_NS + `MCLK_NS - 1) / `MCLK_NS)
`define RESET_REC_CYC     ((`RESET_REC_NS + `MCLK_NS - 1) / `MCLK_NS)
`define VOL_CFG_DEFAULT   8'h00
`endif

// ### design/flash_pkg.sv
// Shared types of the flash command link
package flash_pkg;
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_ENTERING,
		ST_SLEEP,
		ST_WAKING,
		ST_RESETTING
	} mode_type;
	typedef enum logic [1:0] {
		H_IDLE,
		H_SETUP,
		H_SHIFT,
		H_HOLD
	} host_state_type;
endpackage : flash_pkg

// ### design/flash_link_if.sv
// Serial flash link: chip select, serial clock and four data lines
`timescale 1ns/100ps
interface flash_link_if;
	logic       cs_n;
	logic       sck;
	logic [3:0] h_io_out;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_out;
	logic [3:0] d_io_oe;
	logic [3:0] io;
	// Pulled high where nobody drives
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			io[i] = d_io_oe[i] ? d_io_out[i] :
				(h_io_oe[i] ? h_io_out[i] : 1'b1);
	end
	modport host (output cs_n, output sck, output h_io_out, output h_io_oe,
		input io);
	modport dev (input cs_n, input sck, output d_io_out, output d_io_oe,
		input io);
endinterface : flash_link_if

// ### design/flash_host.sv
// Host end: makes the serial clock and runs one command frame per request
`timescale 1ns/100ps
`include "flash_cfg.svh"
module flash_host
	import flash_pkg::*;
#(
	parameter int HALF_DIV = 4
)(
	input  wire logic         mclk,
	input  wire logic         nrst,
	flash_link_if.host        link,
	input  wire logic         req_valid,
	input  wire logic [7:0]   req_op,
	input  wire logic [23:0]  req_addr,
	input  wire logic [2:0]   req_tx_bytes,
	input  wire logic [3:0]   req_rx_bytes,
	input  wire logic         req_quad,
	output logic              busy_q,
	output logic              rx_valid_q,
	output logic [7:0]        rx_data_q,
	output logic              done_q
);
	if (HALF_DIV < 3)
	begin : g_bad_div
		$error("HALF_DIV must be at least 3");
	end
	localparam logic [7:0] HALF_M1 = 8'(HALF_DIV - 1);
	localparam logic [15:0] WAKE_HOLD = 16'(`WAKE_CYC);
	host_state_type st_q;
	logic [7:0]  div_q;
	logic [6:0]  edge_q;
	logic [6:0]  tx_edges_q;
	logic [6:0]  all_edges_q;
	logic        quad_q;
	logic [63:0] tx_q;
	logic [7:0]  rx_sh_q;
	logic [2:0]  rx_bit_q;
	logic [15:0] hold_q;
	logic        long_hold_q;
	logic [3:0]  io_s1_q;
	logic [3:0]  io_s2_q;
	logic        cs_n_q;
	logic        sck_q;
	logic [3:0]  io_out_q;
	logic [3:0]  io_oe_q;
	logic        tick;
	logic        rise;
	logic        fall;
	logic        single;
	assign link.cs_n     = cs_n_q;
	assign link.sck      = sck_q;
	assign link.h_io_out = io_out_q;
	assign link.h_io_oe  = io_oe_q;
	assign tick = (div_q == HALF_M1);
	assign rise = (st_q == H_SHIFT) && tick && !sck_q;
	assign fall = (st_q == H_SHIFT) && tick && sck_q;
	// Mode-bit clear runs on the lowest line only, other lines left alone
	assign single = !req_quad || (req_op == `OP_MODE_BIT_CLEAR);
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			io_s1_q <= 4'h0;
			io_s2_q <= 4'h0;
		end
		else
		begin
			io_s1_q <= link.io;
			io_s2_q <= io_s1_q;
		end
	end
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			div_q <= 8'h00;
		else if (st_q == H_IDLE || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q        <= H_IDLE;
			cs_n_q      <= 1'b1;
			sck_q       <= 1'b0;
			io_out_q    <= 4'h0;
			io_oe_q     <= 4'h0;
			edge_q      <= 7'h00;
			tx_edges_q  <= 7'h00;
			all_edges_q <= 7'h00;
			quad_q      <= 1'b0;
			tx_q        <= 64'h0;
			hold_q      <= 16'h0000;
			long_hold_q <= 1'b0;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			unique case (st_q)
				H_IDLE:
				begin
					if (req_valid)
					begin
						st_q     <= H_SETUP;
						busy_q   <= 1'b1;
						cs_n_q   <= 1'b0;
						quad_q   <= !single;
						tx_q     <= {req_op, req_addr, 32'h0};
						io_out_q <= single ? {3'b000, req_op[7]} :
							req_op[7:4];
						io_oe_q  <= single ? 4'h1 : 4'hF;
						edge_q   <= 7'h00;
						tx_edges_q <= single ?
							7'({req_tx_bytes, 3'b000}) + 7'd8 :
							7'({req_tx_bytes, 1'b0}) + 7'd2;
						all_edges_q <= single ?
							7'({req_tx_bytes, 3'b000}) + 7'd8 +
							7'({req_rx_bytes, 3'b000}) :
							7'({req_tx_bytes, 1'b0}) + 7'd2 +
							7'({req_rx_bytes, 1'b0});
						// Bare wake needs the line idle afterwards
						long_hold_q <= (req_op == `OP_WAKE_ID) &&
							(req_tx_bytes == 3'd0);
					end
				end
				H_SETUP:
					if (tick)
						st_q <= H_SHIFT;
				H_SHIFT:
				begin
					if (rise)
					begin
						sck_q  <= 1'b1;
						edge_q <= edge_q + 7'h01;
					end
					if (fall)
					begin
						sck_q <= 1'b0;
						tx_q  <= quad_q ? {tx_q[59:0], 4'h0} :
							{tx_q[62:0], 1'b0};
						io_out_q <= quad_q ? tx_q[59:56] :
							{3'b000, tx_q[62]};
						if (edge_q >= tx_edges_q)
							io_oe_q <= 4'h0;
						// Select rises right after the last bit
						if (edge_q == all_edges_q)
						begin
							st_q    <= H_HOLD;
							cs_n_q  <= 1'b1;
							io_oe_q <= 4'h0;
							hold_q  <= long_hold_q ? WAKE_HOLD :
								16'(2 * HALF_DIV);
						end
					end
				end
				H_HOLD:
				begin
					if (hold_q == 16'h0000)
					begin
						st_q   <= H_IDLE;
						busy_q <= 1'b0;
						done_q <= 1'b1;
					end
					else
						hold_q <= hold_q - 16'h0001;
				end
			endcase
		end
	end
	// Receive phase sampled from the synchronised lines at each rise
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_sh_q    <= 8'h00;
			rx_bit_q   <= 3'd0;
			rx_valid_q <= 1'b0;
			rx_data_q  <= 8'h00;
		end
		else
		begin
			rx_valid_q <= 1'b0;
			if (st_q == H_IDLE)
				rx_bit_q <= 3'd0;
			else if (rise && edge_q >= tx_edges_q)
			begin
				rx_sh_q <= quad_q ? {rx_sh_q[3:0], io_s2_q} :
					{rx_sh_q[6:0], io_s2_q[1]};
				rx_bit_q <= quad_q ? rx_bit_q + 3'd4 :
					rx_bit_q + 3'd1;
				if ((quad_q && rx_bit_q == 3'd4) ||
					(!quad_q && rx_bit_q == 3'd7))
				begin
					rx_valid_q <= 1'b1;
					rx_data_q  <= quad_q ? {rx_sh_q[3:0], io_s2_q} :
						{rx_sh_q[6:0], io_s2_q[1]};
				end
			end
		end
	end
endmodule : flash_host

// ### test/flash_link_assertions.sv
// Concurrent checks on the flash link and the device status outputs
`timescale 1ns/100ps
module flash_link_assertions (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic [3:0] d_io_out,
	input  wire logic [3:0] d_io_oe,
	input  wire logic       ready_q,
	input  wire logic       sleeping_q,
	input  wire logic       soft_reset_q,
	input  wire logic [1:0] prot_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic [9:0] since_cs_q;
	// Clock cycles since select went high; saturates so long idles stay valid
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			since_cs_q <= 10'h000;
		else if (!cs_n)
			since_cs_q <= 10'h000;
		else if (since_cs_q != 10'h3FF)
			since_cs_q <= since_cs_q + 10'h001;
	end
	AST_DEV_RELEASE: assert property (cs_n |-> d_io_oe == 4'h0)
		else $error("device drives with select high");
	AST_SCK_IDLE: assert property (cs_n |-> !sck)
		else $error("serial clock high outside a frame");
	AST_DEV_LANES: assert property (d_io_oe inside {4'h0, 4'h2, 4'hF})
		else $error("device drives an odd set of lines");
	AST_OUT_ON_FALL: assert property (
		$changed(d_io_out) && d_io_oe != 4'h0 && $past(d_io_oe) != 4'h0
		|-> !sck && $past(sck))
		else $error("read data moved off a falling edge");
	AST_SLEEP_ENTRY: assert property ($rose(sleeping_q)
		|-> since_cs_q inside {[58:72]})
		else $error("sleep entered at the wrong time");
	AST_SLEEP_SILENT: assert property (sleeping_q |-> d_io_oe == 4'h0)
		else $error("device answers while asleep");
	AST_WAKE_TIME: assert property ($rose(ready_q)
		|-> since_cs_q >= 10'd60)
		else $error("ready before the wake time");
	AST_RESET_RECOVERY: assert property (soft_reset_q
		|-> since_cs_q >= 10'd200)
		else $error("soft reset ended before recovery");
	AST_PROT_KEPT: assert property (soft_reset_q |-> $stable(prot_q)
		##1 $stable(prot_q))
		else $error("soft reset touched protect bits");
endmodule : flash_link_assertions

// ### test/tb_flash_reset_sleep_and_param_access.sv
// Self-checking bench joining host and device ends over the flash link
`timescale 1ns/100ps
`include "flash_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_flash_reset_sleep_and_param_access;
	localparam logic [7:0] ID_VAL = 8'h5E; // Arbitrary value
	logic        mclk = 1'b0;
	logic        nrst;
	logic        req_valid;
	logic [7:0]  req_op;
	logic [23:0] req_addr;
	logic [2:0]  req_tx_bytes;
	logic [3:0]  req_rx_bytes;
	logic        req_quad;
	logic        busy_q;
	logic        rx_valid_q;
	logic [7:0]  rx_data_q;
	logic        done_q;
	logic        quad_mode;
	logic        busy;
	logic        cont_read_enter;
	logic        cfg_wr;
	logic [9:0]  cfg_wr_data;
	logic        ready_q;
	logic        sleeping_q;
	logic        cont_read_q;
	logic        soft_reset_q;
	logic [7:0]  vol_cfg_q;
	logic [1:0]  prot_q;
	logic [7:0]  e_v;
	logic [7:0]  v;
	logic [7:0]  exp_q[$];
	int          n_fail = 0;
	int          n_tests = 0;
	int          n_soft = 0;
	int          cyc = 0;
	int          seed;
	flash_link_if u_flash_link_if();
	flash_host u_flash_host (.mclk(mclk), .nrst(nrst), .link(u_flash_link_if),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
		.req_tx_bytes(req_tx_bytes), .req_rx_bytes(req_rx_bytes),
		.req_quad(req_quad), .busy_q(busy_q), .rx_valid_q(rx_valid_q),
		.rx_data_q(rx_data_q), .done_q(done_q));
	flash_device #(.DEVICE_ID(ID_VAL)) u_flash_device (.mclk(mclk),
		.nrst(nrst), .link(u_flash_link_if), .quad_mode(quad_mode),
		.busy(busy), .cont_read_enter(cont_read_enter), .cfg_wr(cfg_wr),
		.cfg_wr_data(cfg_wr_data), .ready_q(ready_q),
		.sleeping_q(sleeping_q), .cont_read_q(cont_read_q),
		.soft_reset_q(soft_reset_q), .vol_cfg_q(vol_cfg_q), .prot_q(prot_q));
	flash_link_assertions chk (.mclk(mclk), .nrst(nrst),
		.cs_n(u_flash_link_if.cs_n), .sck(u_flash_link_if.sck),
		.d_io_out(u_flash_link_if.d_io_out), .d_io_oe(u_flash_link_if.d_io_oe),
		.ready_q(ready_q), .sleeping_q(sleeping_q),
		.soft_reset_q(soft_reset_q), .prot_q(prot_q));
	always #25 mclk = ~mclk;
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// Hang guard, well above the longest expected run
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			complete_run();
		end
	end
	always @(posedge mclk)
		if (soft_reset_q === 1'b1)
			n_soft++;
	always @(posedge mclk)
		if (rx_valid_q === 1'b1)
		begin
			e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
			`CHK("rx_data", e_v, rx_data_q)
		end
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask : step
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input logic [2:0] tx, input logic [3:0] rx, input logic q,
		input logic [63:0] ex);
		int n;
		for (int i = 0; i < rx; i++)
			exp_q.push_back(ex[63 - 8 * i -: 8]);
		@(posedge mclk);
		req_op <= op;
		req_addr <= a;
		req_tx_bytes <= tx;
		req_rx_bytes <= rx;
		req_quad <= q;
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		@(posedge mclk);
		`CHK("busy", 1'b1, busy_q)
		n = 0;
		while (done_q !== 1'b1 && n < 3000)
		begin
			@(posedge mclk);
			n++;
		end
		`CHK("frame_done", 1'b1, done_q)
		`CHK("idle", 1'b0, busy_q)
		if (done_q !== 1'b1)
			complete_run();
	endtask : frame
	task automatic end_test(input string nm);
		`CHK("rx_count", 0, exp_q.size())
		$display("test %s done", nm);
	endtask : end_test
	// Device latches the quad setting only on link edges, hence dummy frame
	task automatic set_quad(input logic q);
		quad_mode <= q;
		frame(8'h00, 24'h0, 3'd0, 4'd0, q, 64'h0);
	endtask : set_quad
	initial
	begin
		seed = 86518;
		nrst = 1'b0;
		{req_valid, req_op, req_addr, req_tx_bytes, req_rx_bytes} = '0;
		{req_quad, quad_mode, busy, cont_read_enter, cfg_wr} = '0;
		cfg_wr_data = 10'h000;
		step(2);
		nrst <= 1'b1;
		frame(8'hAB, 24'h0, 3'd3, 4'd2, 1'b0, {ID_VAL, 56'h0});
		set_quad(1'b1);
		frame(8'hAB, 24'h0, 3'd3, 4'd1, 1'b1, {ID_VAL, 56'h0});
		set_quad(1'b0);
		end_test("identify");
		frame(8'h5A, 24'h0, 3'd4, 4'd8, 1'b0, 64'h5346445006010_1FF);
		frame(8'h5A, 24'h34F, 3'd4, 4'd2, 1'b0, {16'hA5FF, 48'h0});
		repeat (4)
			frame(8'h5A, 24'h300 + 24'($unsigned($random(seed)) % 80),
				3'd4, 4'd1, 1'b0, {8'hA5, 56'h0});
		frame(8'h02, 24'h0, 3'd4, 4'd0, 1'b0, 64'h0);
		frame(8'h5A, 24'h0, 3'd4, 4'd1, 1'b0, {8'h53, 56'h0});
		end_test("param_space");
		// Top bit differs from the default, so a reload always shows
		v = ~`VOL_CFG_DEFAULT ^ {1'b0, 7'($random(seed))};
		@(posedge mclk);
		cfg_wr <= 1'b1;
		cfg_wr_data <= {2'b11, v};
		@(posedge mclk);
		cfg_wr <= 1'b0;
		frame(8'h66, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		frame(8'h05, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		frame(8'h99, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		step(250);
		`CHK("soft_count", 0, n_soft)
		`CHK("cfg_kept", v, vol_cfg_q)
		frame(8'hFF, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		frame(8'h66, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		frame(8'h99, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		step(250);
		`CHK("soft_count", 1, n_soft)
		`CHK("cfg_reload", `VOL_CFG_DEFAULT, vol_cfg_q)
		`CHK("prot_soft", 2'b11, prot_q)
		end_test("soft_reset");
		@(posedge mclk);
		cont_read_enter <= 1'b1;
		@(posedge mclk);
		cont_read_enter <= 1'b0;
		step(2);
		`CHK("cont_read", 1'b1, cont_read_q)
		frame(8'hAB, 24'h0, 3'd3, 4'd1, 1'b0, {8'hFF, 56'h0});
		frame(8'hFF, 24'h0, 3'd0, 4'd0, 1'b1, 64'h0);
		step(4);
		`CHK("cont_read", 1'b0, cont_read_q)
		busy <= 1'b1;
		frame(8'hAB, 24'h0, 3'd3, 4'd1, 1'b0, {8'hFF, 56'h0});
		busy <= 1'b0;
		end_test("mode_clear");
		frame(8'hB9, 24'h0, 3'd1, 4'd0, 1'b0, 64'h0);
		step(80);
		`CHK("sleeping", 1'b0, sleeping_q)
		frame(8'hB9, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		step(70);
		`CHK("sleeping", 1'b1, sleeping_q)
		frame(8'h05, 24'h0, 3'd0, 4'd1, 1'b0, {8'hFF, 56'h0});
		frame(8'h5A, 24'h0, 3'd4, 4'd1, 1'b0, {8'hFF, 56'h0});
		frame(8'hAB, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		step(20);
		`CHK("ready", 1'b1, ready_q)
		frame(8'hAB, 24'h0, 3'd3, 4'd1, 1'b0, {ID_VAL, 56'h0});
		frame(8'hB9, 24'h0, 3'd0, 4'd0, 1'b0, 64'h0);
		step(70);
		nrst <= 1'b0;
		step(2);
		nrst <= 1'b1;
		step(1);
		`CHK("awake", 1'b0, sleeping_q)
		`CHK("prot_hard", 2'b00, prot_q)
		frame(8'hAB, 24'h0, 3'd3, 4'd1, 1'b0, {ID_VAL, 56'h0});
		end_test("deep_sleep");
		complete_run();
	end
endmodule : tb_flash_reset_sleep_and_param_access
